// ===== fhe_half_full_echo.sv
// Half-full flag, echo read strobes, serial offset load and bus matching.
// Assumes write and read agents are logic on i_core_clk; serial clock is a pin.
// Contract
// - Half-full goes low on the write edge taking occupancy above half depth.
// - Half-full returns high on the read edge bringing occupancy to half or less.
// - Standard mode: half-full after depth/2 plus one writes from reset.
// - Depth is a parameter from 2048; doubles when both ports are 9 bits.
// - Fall-through mode: half-full after depth/2 plus two writes.
// - Half-full is moved by both write and read events.
// - Echo read clock follows the read clock, ignoring enables.
// - Echo read clock is a registered toggle, changing on the same edge as data outputs.
// - Echo read enable low for a cycle when a real read occurs.
// - Serial bit shifted in per serial clock rise while load enable low.
// - Output gives 18 bits, or low 9 bits in 9-bit mode.
// - Byte order, input and output width selects choose port mode.
// - 18-in 9-out: one word read as two bytes in endian order.
// - 9-in 18-out: two writes packed into one word by endian order.
// - Fall-through occupancy counts the output register word too.
module fhe_half_full_echo #(
    parameter int DEPTH = 2048,
    parameter int SER_W = 16
) (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_master_reset_n,
    input wire logic i_partial_reset_n,
    input wire logic i_first_word_fall_through_mode,
    input wire logic i_byte_order_select,
    input wire logic i_input_width_select,
    input wire logic i_output_width_select,
    input wire logic i_write_en_n,
    input wire logic [fhe_pkg::FHE_WORD_W-1:0] i_write_data,
    input wire logic i_read_en_n,
    input wire logic i_read_chip_select_n,
    input wire logic i_serial_clock,
    input wire logic i_serial_load_enable_n,
    input wire logic i_serial_in,
    output logic o_half_full_n,
    output logic o_echo_read_clock,
    output logic o_echo_read_enable_n,
    output logic o_empty,
    output logic o_full,
    output logic [fhe_pkg::FHE_WORD_W-1:0] o_read_data_out,
    output logic [SER_W-1:0] o_flag_offset
);
    import fhe_pkg::*;
    localparam int EDEPTH = 2 * DEPTH;
    localparam int CW = $clog2(EDEPTH + 2) + 1;
    // Array index one bit wider than the capacity needs: the fall-through
    // extra word then never aliases a live lane, at the cost of a doubled array
    localparam int AW = $clog2(EDEPTH) + 1;
    // Refuse depths the pointer wrap cannot serve, and a shifter too short to shift
    if (DEPTH < FHE_MIN_DEPTH || 2 * DEPTH > FHE_MAX_DEPTH || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two within range");
    end
    if (SER_W < 2) begin : g_bad_ser
        $error("SER_W must be at least two");
    end
    // ==================================================
    // Mode decode
    logic nine_in;
    logic nine_out;
    logic both_nine;
    logic [CW-1:0] cap;
    logic [CW-1:0] half;
    logic [1:0] word_lanes;
    logic [CW-1:0] extra;
    logic rst_any;
    assign nine_in = i_input_width_select;
    assign nine_out = i_output_width_select;
    assign both_nine = nine_in & nine_out;
    // One stored word in lanes: a 9-bit word only when both ports are narrow
    assign word_lanes = both_nine ? 2'd1 : 2'd2;
    // Fall-through holds one more word in the output stage
    assign extra = i_first_word_fall_through_mode ? CW'(word_lanes) : CW'(0);
    // Capacity in lanes is twice DEPTH in every width mode, plus the held word
    assign cap = CW'(EDEPTH) + extra;
    // Half-full threshold: half the lane capacity, plus the held word
    assign half = CW'(DEPTH) + extra;
    assign rst_any = i_srst | ~i_master_reset_n | ~i_partial_reset_n;
    // ==================================================
    // Lane storage: memory holds 9-bit lanes, pointers count lanes
    logic [FHE_LANE_W-1:0] mem [0:(1 << AW) - 1];
    logic [CW-1:0] wptr_reg;
    logic [CW-1:0] wptr_next;
    logic [CW-1:0] rptr_reg;
    logic [CW-1:0] rptr_next;
    logic [CW-1:0] used;
    logic wr_ok;
    logic rd_ok;
    logic [1:0] wr_lanes;
    logic [1:0] rd_lanes;
    logic [FHE_WORD_W-1:0] q_reg;
    logic [FHE_WORD_W-1:0] q_next;
    logic hf_n_reg;
    logic hf_n_next;
    logic echo_read_enable_n_n_reg;
    logic echo_read_enable_n_n_next;
    logic [CW-1:0] used_after;
    function automatic logic [FHE_LANE_W-1:0] lane_of(input logic [FHE_WORD_W-1:0] w, input logic upper);
        lane_of = upper ? w[FHE_WORD_W-1:FHE_LANE_W] : w[FHE_LANE_W-1:0];
    endfunction
    assign used = wptr_reg - rptr_reg;
    assign wr_lanes = nine_in ? 2'd1 : 2'd2;
    assign rd_lanes = nine_out ? 2'd1 : 2'd2;
    assign wr_ok = ~i_write_en_n & (used + CW'(wr_lanes) <= cap);
    assign rd_ok = ~i_read_en_n & ~i_read_chip_select_n & (used >= CW'(rd_lanes));
    assign o_empty = used < CW'(rd_lanes);
    assign o_full = used + CW'(wr_lanes) > cap;
    // Next pointers, data and flags
    always_comb begin
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        q_next = q_reg;
        echo_read_enable_n_n_next = FHE_ECHO_READ_ENABLE_N_N_RST;
        hf_n_next = hf_n_reg;
        if (wr_ok) begin
            wptr_next = wptr_reg + CW'(wr_lanes);
        end
        if (rd_ok) begin
            rptr_next = rptr_reg + CW'(rd_lanes);
            echo_read_enable_n_n_next = 1'b0;
            if (nine_out) begin
                // One lane per read, low 9 bits only
                q_next = {{FHE_LANE_W{1'b0}}, mem[rptr_reg[AW-1:0]]};
            end else begin
                // First lane upper, except 9-bit input in little endian
                // An 18-bit word written little endian is stored lower lane first,
                // so reading it back first-lane-upper gives the swapped word
                q_next = (i_byte_order_select && nine_in) ?
                    {mem[AW'(rptr_reg + CW'(1))], mem[rptr_reg[AW-1:0]]} :
                    {mem[rptr_reg[AW-1:0]], mem[AW'(rptr_reg + CW'(1))]};
            end
        end
        used_after = wptr_next - rptr_next;
        // Write sets low on exceeding half, read releases at half or less
        if (wr_ok && used_after > half) begin
            hf_n_next = 1'b0;
        end else if (rd_ok && used_after <= half) begin
            hf_n_next = 1'b1;
        end
    end
    // Memory write: lanes placed by endian order
    always_ff @(posedge i_core_clk) begin
        if (wr_ok) begin
            if (nine_in) begin
                mem[wptr_reg[AW-1:0]] <= i_write_data[FHE_LANE_W-1:0];
            end else begin
                mem[wptr_reg[AW-1:0]] <= lane_of(i_write_data, ~i_byte_order_select);
                mem[AW'(wptr_reg + CW'(1))] <= lane_of(i_write_data, i_byte_order_select);
            end
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (rst_any) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            hf_n_reg <= FHE_HF_N_RST;
            echo_read_enable_n_n_reg <= FHE_ECHO_READ_ENABLE_N_N_RST;
            q_reg <= '0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            hf_n_reg <= hf_n_next;
            echo_read_enable_n_n_reg <= echo_read_enable_n_n_next;
            q_reg <= q_next;
        end
    end
    assign o_half_full_n = hf_n_reg;
    assign o_echo_read_enable_n = echo_read_enable_n_n_reg; // Marks the cycle of a new word
    assign o_read_data_out = q_reg;
    // ==================================================
    // Echo clock: toggles every core edge, free running
    // Registered, so it changes on the same core edge as the data output update
    logic echo_read_clock_reg;
    logic echo_read_clock_next;
    always_comb begin
        echo_read_clock_next = ~echo_read_clock_reg;
    end
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            echo_read_clock_reg <= 1'b0;
        end else begin
            echo_read_clock_reg <= echo_read_clock_next;
        end
    end
    assign o_echo_read_clock = echo_read_clock_reg;
    // ==================================================
    // Serial offset load on synchronised serial clock rise
    logic sclk_rise;
    logic sen_n_lvl;
    logic si_lvl;
    logic [SER_W-1:0] off_reg;
    logic [SER_W-1:0] off_next;
    // Reset values match the idle pin levels, so no false edge follows reset
    fhe_pin_sync u_sclk (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_pin(i_serial_clock),
        .i_rst_val(1'b0),
        .o_level(),
        .o_rise(sclk_rise)
    );
    fhe_pin_sync u_sen (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_pin(i_serial_load_enable_n),
        .i_rst_val(1'b1),
        .o_level(sen_n_lvl),
        .o_rise()
    );
    fhe_pin_sync u_si (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_pin(i_serial_in),
        .i_rst_val(1'b0),
        .o_level(si_lvl),
        .o_rise()
    );
    always_comb begin
        off_next = off_reg;
        if (sclk_rise && !sen_n_lvl) begin
            off_next = {off_reg[SER_W-2:0], si_lvl};
        end
    end
    // Offsets survive partial reset, cleared by master reset
    always_ff @(posedge i_core_clk) begin
        if (i_srst || !i_master_reset_n) begin
            off_reg <= SER_W'(FHE_OFFSET_RST);
        end else begin
            off_reg <= off_next;
        end
    end
    assign o_flag_offset = off_reg;
endmodule

// ===== fhe_pkg.sv
// Package for the half-full / echo read port block.
// Assumes a single 25 MHz core clock and synchronous active-high reset.
package fhe_pkg;
    // ==================================================
    // Widths and depths
    localparam int FHE_LANE_W = 9;
    localparam int FHE_WORD_W = 18;
    localparam int FHE_MIN_DEPTH = 2048;
    localparam int FHE_MAX_DEPTH = 1048576;
    // ==================================================
    // Reset values
    localparam logic FHE_HF_N_RST = 1'b1;
    localparam logic FHE_ECHO_READ_ENABLE_N_N_RST = 1'b1;
    localparam logic [15:0] FHE_OFFSET_RST = 16'h0000;
    // ==================================================
    // Serial offset register length
    localparam int FHE_SER_W = 16;
    // Pin synchroniser depth
    localparam int FHE_SYNC_STAGES = 3;
    // Lane select for bus matching
    typedef enum logic [1:0] {
        FHE_LANE_FIRST = 2'b01,
        FHE_LANE_SECOND = 2'b10
    } fhe_lane_t;
endpackage

// ===== fhe_pin_sync.sv
// Three-stage synchroniser for a pin input.
// Assumes the pin is asynchronous to i_core_clk.
module fhe_pin_sync (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_pin,
    input wire logic i_rst_val,
    output logic o_level,
    output logic o_rise
);
    import fhe_pkg::*;
    // ==================================================
    // Chain
    logic [FHE_SYNC_STAGES-1:0] sh_reg;
    logic [FHE_SYNC_STAGES-1:0] sh_next;
    logic lvl_reg;
    logic lvl_next;
    // Change counts once stages two and three agree
    always_comb begin
        sh_next = {sh_reg[FHE_SYNC_STAGES-2:0], i_pin};
        lvl_next = lvl_reg;
        if (sh_reg[1] == sh_reg[2]) begin
            lvl_next = sh_reg[2];
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            sh_reg <= {FHE_SYNC_STAGES{i_rst_val}};
            lvl_reg <= i_rst_val;
        end else begin
            sh_reg <= sh_next;
            lvl_reg <= lvl_next;
        end
    end
    assign o_level = lvl_reg;
    assign o_rise = lvl_next & ~lvl_reg;
endmodule

// ===== fhe_half_full_echo_checker.sv
// Port checker for the half-full flag and echo read block.
// Assumes one core clock and sync reset; bound to the top by name.
module fhe_half_full_echo_checker #(parameter int SER_W = 16) (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_master_reset_n,
    input wire logic i_partial_reset_n,
    input wire logic i_output_width_select,
    input wire logic i_write_en_n,
    input wire logic i_read_en_n,
    input wire logic i_read_chip_select_n,
    input wire logic i_serial_load_enable_n,
    input wire logic o_half_full_n,
    input wire logic o_echo_read_clock,
    input wire logic o_echo_read_enable_n,
    input wire logic o_empty,
    input wire logic o_full,
    input wire logic [fhe_pkg::FHE_WORD_W-1:0] o_read_data_out,
    input wire logic [SER_W-1:0] o_flag_offset
);
    import fhe_pkg::*;
    // ==================================================
    // A read counts only outside the reset pins and when not empty
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_srst);
    wire logic pins_ok = i_master_reset_n && i_partial_reset_n;
    wire logic rd_ok = pins_ok && !i_read_en_n && !i_read_chip_select_n && !o_empty;
    echo_read_enable_n_go_a: assert property (rd_ok |=> !o_echo_read_enable_n) else $error("echo strobe missing");
    echo_read_enable_n_why_a: assert property (!o_echo_read_enable_n |-> $past(rd_ok)) else $error("stray echo strobe");
    echo_run_a: assert property (1'b1 |=> $changed(o_echo_read_clock)) else $error("echo clock stuck");
    hf_set_a: assert property ($fell(o_half_full_n) |-> $past(!i_write_en_n)) else $error("flag set without write");
    hf_clr_a: assert property ($rose(o_half_full_n) |-> $past(rd_ok || !pins_ok)) else $error("flag cleared oddly");
    hf_full_a: assert property (o_full |-> !o_half_full_n) else $error("full but flag high");
    hf_empty_a: assert property (o_empty |-> o_half_full_n) else $error("empty but flag low");
    data_hold_a: assert property (o_echo_read_enable_n && $past(pins_ok) |-> $stable(o_read_data_out))
        else $error("data moved without read");
    lane_nine_a: assert property ($past(i_output_width_select) && !o_echo_read_enable_n |-> o_read_data_out[17:9] == 9'h000)
        else $error("upper lane not zero");
    ser_still_a: assert property ((i_serial_load_enable_n && i_master_reset_n) [*6] |-> $stable(o_flag_offset))
        else $error("offset moved while disabled");
endmodule
bind fhe_half_full_echo fhe_half_full_echo_checker #(.SER_W(SER_W)) u_chk (.*);

// ===== fhe_ser_host.sv
// Serial offset loader standing on the far side of the serial pins.
// Assumes the core clock; serial clock rests low between frames.
module fhe_ser_host (
    input wire logic i_core_clk,
    output logic o_serial_clock,
    output logic o_serial_load_enable_n,
    output logic o_serial_in
);
    initial begin
        o_serial_clock = 1'b0;
        o_serial_load_enable_n = 1'b1;
        o_serial_in = 1'b0;
    end
    // ==================================================
    // Slow bits, four core cycles high and five low, so the synchroniser sees each edge
    task automatic load(input logic [15:0] v, input logic en_n);
        for (int i = 15; i >= 0; i--) begin
            @(posedge i_core_clk);
            o_serial_load_enable_n <= en_n;
            o_serial_in <= v[i];
            repeat (4) @(posedge i_core_clk);
            o_serial_clock <= 1'b1;
            repeat (4) @(posedge i_core_clk);
            o_serial_clock <= 1'b0;
        end
        @(posedge i_core_clk);
        o_serial_load_enable_n <= 1'b1;
        o_serial_in <= ~v[0]; // Released line must not keep the last bit
    endtask
endmodule

// ===== fhe_half_full_echo_bench.sv
// Bench for the half-full flag, echo strobe, serial load and bus matching.
// Assumes the design package and the serial host model are compiled first.
module fhe_half_full_echo_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import fhe_pkg::*;
    localparam int D = 2048;
    logic i_core_clk = 1'b0, i_srst = 1'b1, i_master_reset_n = 1'b1, i_partial_reset_n = 1'b1;
    logic i_first_word_fall_through_mode = 1'b0, i_byte_order_select = 1'b0, i_input_width_select = 1'b0;
    logic i_output_width_select = 1'b0, i_write_en_n = 1'b1, i_read_en_n = 1'b1, i_read_chip_select_n = 1'b1;
    logic [17:0] i_write_data = 18'h00000;
    logic i_serial_clock, i_serial_load_enable_n, i_serial_in, o_half_full_n, o_echo_read_clock;
    logic o_echo_read_enable_n, o_empty, o_full;
    logic [17:0] o_read_data_out;
    logic [15:0] o_flag_offset, pal;
    logic ek;
    logic [17:0] exp_q[$];
    int errors = 0, checked = 0, cyc = 0;
    fhe_half_full_echo #(.DEPTH(D), .SER_W(16)) dut (.*);
    fhe_ser_host u_ser (.i_core_clk(i_core_clk), .o_serial_clock(i_serial_clock),
        .o_serial_load_enable_n(i_serial_load_enable_n), .o_serial_in(i_serial_in));
    // ==================================================
    // Clock and hang guard
    always #20 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cw(input logic [17:0] g, input logic [17:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cf(input logic g, input logic e);
        cw({17'h00000, g}, {17'h00000, e});
    endtask
    function automatic logic [8:0] lane(input logic [17:0] w, input logic second, input logic le);
        return (second ^ le) ? w[8:0] : w[17:9];
    endfunction
    // Back-to-back writes of random units, kept for later comparison
    task automatic wr(input int n, input logic [17:0] m);
        logic [17:0] v;
        repeat (n) begin
            @(posedge i_core_clk);
            v = 18'($urandom) & m;
            i_write_en_n <= 1'b0;
            i_write_data <= v;
            exp_q.push_back(v);
        end
        @(posedge i_core_clk);
        i_write_en_n <= 1'b1;
        #1;
    endtask
    // One read request; ok says whether the design should take it
    task automatic rd(input logic cs, input logic ok, input logic [17:0] e);
        @(posedge i_core_clk);
        i_read_en_n <= 1'b0;
        i_read_chip_select_n <= cs;
        @(posedge i_core_clk);
        i_read_en_n <= 1'b1;
        i_read_chip_select_n <= 1'b1;
        #1;
        cf(o_echo_read_enable_n, !ok);
        if (ok) cw(o_read_data_out, e);
    endtask
    task automatic setup(input logic fw, input int k);
        @(posedge i_core_clk);
        i_first_word_fall_through_mode <= fw;
        {i_input_width_select, i_byte_order_select} <= 2'(k);
        i_output_width_select <= ~(k[1] | k[2]);
        @(posedge i_core_clk);
        i_partial_reset_n <= 1'b0;
        @(posedge i_core_clk);
        i_partial_reset_n <= 1'b1;
        exp_q.delete();
    endtask
    initial begin
        void'($urandom(44271));
        repeat (10) @(posedge i_core_clk);
        i_srst <= 1'b0;
        wr(D / 2, 18'h3ffff);
        cf(o_half_full_n, 1'b1);
        wr(1, 18'h3ffff);
        cf(o_half_full_n, 1'b0);
        rd(1'b0, 1'b1, exp_q.pop_front());
        cf(o_half_full_n, 1'b1);
        rd(1'b1, 1'b0, 18'h00000);
        while (exp_q.size() > 0) rd(1'b0, 1'b1, exp_q.pop_front());
        cf(o_empty, 1'b1);
        rd(1'b0, 1'b0, 18'h00000);
        // Echo clock must change between two neighbouring edges, reads or not
        @(posedge i_core_clk);
        #1;
        ek = o_echo_read_clock;
        @(posedge i_core_clk);
        #1;
        cf(o_echo_read_clock, ~ek);
        setup(1'b1, 0);
        wr(D / 2 + 1, 18'h3ffff);
        cf(o_half_full_n, 1'b1);
        wr(1, 18'h3ffff);
        cf(o_half_full_n, 1'b0);
        // Fill to capacity: fall-through holds depth plus one words
        wr(D / 2 - 2, 18'h3ffff);
        cf(o_full, 1'b0);
        wr(1, 18'h3ffff);
        cf(o_full, 1'b1);
        // Modes 4 and 5 are 18-bit in to 18-bit out, big then little endian
        for (int k = 0; k < 6; k++) begin
            setup(1'b0, k);
            wr(2, k[1] ? 18'h001ff : 18'h3ffff);
            if (k[1]) rd(1'b0, 1'b1, k[0] ? {exp_q[1][8:0], exp_q[0][8:0]} : {exp_q[0][8:0], exp_q[1][8:0]});
            else if (k[2]) begin
                for (int j = 0; j < 2; j++) begin
                    rd(1'b0, 1'b1, {lane(exp_q[j], 1'b0, k[0]), lane(exp_q[j], 1'b1, k[0])});
                end
            end
            else for (int j = 0; j < 4; j++) rd(1'b0, 1'b1, {9'h000, lane(exp_q[j / 2], j[0], k[0])});
        end
        pal[15:8] = 8'($urandom);
        pal[7:0] = {<<{pal[15:8]}};
        u_ser.load(pal, 1'b0);
        repeat (6) @(posedge i_core_clk);
        cw({2'h0, o_flag_offset}, {2'h0, pal});
        u_ser.load(~pal, 1'b1);
        repeat (6) @(posedge i_core_clk);
        cw({2'h0, o_flag_offset}, {2'h0, pal});
        // Master reset clears the flag, the contents and the loaded offsets
        wr(D / 2 + 1, 18'h3ffff);
        cf(o_half_full_n, 1'b0);
        @(posedge i_core_clk);
        i_master_reset_n <= 1'b0;
        @(posedge i_core_clk);
        i_master_reset_n <= 1'b1;
        #1;
        cf(o_half_full_n, 1'b1);
        cf(o_empty, 1'b1);
        cw({2'h0, o_flag_offset}, {2'h0, FHE_OFFSET_RST});
        print_verdict();
    end
endmodule
